//--- shared/srx_pkg.sv
// constants, register layout and types for the serial receive lane
// How it works
// RL1 - rate 00 samples every cycle, 01 every second, 10 every fourth; 11 takes none
// RL2 - software picks the reference clock from line rate, ratio factor and multiplier
// RL3 - receiver off clears and stops the receive logic except the symbol FIFO and overflow flag, which keep their state;
// lane registers sit at 100h-10Ch; the code keeps jog_pending through receiver off, so a jog armed while off slips on the first sample
// RL4 - flagged signal loss with detection on freezes recovery phase and frequency
// RL5 - loss select in bits 15-14: 00 off, 01 high, 10 low, 11 reserved
// RL6 - phase sample between differing data is a vote; eight-sample window, act on majority
// RL7 - first order steps once per majority; second order integrates majorities and steps
// RL8 - recovery bits 18-16: low two bits pick order and dynamics, top bit fast lock
// RL9 - alignment 00 never realigns, even when switching into it
// RL10 - alignment 01 realigns the ten-bit boundary on an off-boundary comma
// RL11 - each rise of the alignment upper bit in jog mode slips the boundary one bit
// RL12 - fully adaptive equalizer: gain at min lowers zero, gain at max raises zero
// RL13 - equalizer decisions come from votes over a long analysis window
// RL14 - polarity bit 7 set inverts every received sample
// RL15 - software writes only 001b to termination bits 10-8
// RL16 - software writes 000b to parallel width bits 4-2
// RL17 - bits 31-26, 23 and 11 read zero; software writes zero to 25-24 and 1
// RL18 - bit 0 is the receiver enable
// RL19 - loss input is synchronised and ignored while detection is off
package srx_pkg;

    // ==========================================================
    // register map
    localparam logic [11:0] CFG_BASE = 12'h100;
    localparam logic [11:0] CFG_LAST = 12'h10C;
    localparam logic [11:0] CFG_STRIDE = 12'h004;
    localparam logic [11:0] STAT_ADDR = 12'h180;
    localparam logic [31:0] CFG_RESET = 32'h00000000;
    localparam logic [31:0] CFG_WR_MASK = 32'h037FF7FF;
    localparam int STAT_PHASE_LSB = 0;
    localparam int STAT_FREQ_LSB = 8;
    localparam int STAT_GAIN_LSB = 16;
    localparam int STAT_ZERO_LSB = 20;
    localparam int STAT_LOS_BIT = 24;
    localparam int STAT_OVF_BIT = 25;

    // ==========================================================
    // field codes
    localparam logic [1:0] RATE_FULL = 2'h0;
    localparam logic [1:0] RATE_HALF = 2'h1;
    localparam logic [1:0] RATE_QUARTER = 2'h2;
    localparam logic [1:0] LOS_OFF = 2'h0;
    localparam logic [1:0] LOS_HIGH = 2'h1;
    localparam logic [1:0] LOS_LOW = 2'h2;
    localparam logic [1:0] ALIGN_OFF = 2'h0;
    localparam logic [1:0] ALIGN_COMMA = 2'h1;
    localparam logic [1:0] ALIGN_JOG = 2'h2;
    localparam logic [3:0] EQ_FLAT = 4'h0;
    localparam logic [3:0] EQ_FULL = 4'h1;

    // ==========================================================
    // datapath constants
    localparam int SYM_W = 10;
    localparam logic [3:0] SYM_LAST = 4'h9;
    localparam logic [6:0] COMMA_POS = 7'h1F;
    localparam logic [6:0] COMMA_NEG = 7'h60;
    localparam logic [2:0] VOTE_LAST = 3'h7;
    localparam logic signed [12:0] DRIFT_THR1 = 13'sh0400;
    localparam logic signed [12:0] DRIFT_THR2 = 13'sh0200;
    localparam logic signed [12:0] DRIFT_THR3 = 13'sh0100;
    localparam logic signed [7:0] FREQ_LIM = 8'sh64;
    localparam logic [3:0] GAIN_MAX = 4'hF;
    localparam logic [3:0] GAIN_MIN = 4'h0;
    localparam logic [2:0] ZERO_MAX = 3'h7;
    localparam logic [2:0] ZERO_MIN = 3'h0;
    localparam int EQ_WINDOW_DEF = 1024;
    localparam int FIFO_DEPTH_DEF = 16;

    typedef struct packed {
        logic [5:0] ro_hi;
        logic [1:0] rsv_wr;
        logic ro23;
        logic [3:0] gain_shaping;
        logic [2:0] recovery;
        logic [1:0] loss_sel;
        logic [1:0] align;
        logic ro11;
        logic [2:0] term;
        logic polarity;
        logic [1:0] rate;
        logic [2:0] width;
        logic rsv1;
        logic rx_on;
    } srx_cfg_t;

endpackage

//--- logic/srx_fifo.sv
// symbol FIFO with registered read data
`timescale 1ns/10ps
module srx_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    always_comb begin
        in_ready_out = (count != (AW+1)'(DEPTH));
        push = in_valid_in && in_ready_out;
        pop = (!out_valid_out || out_ready_in) && (count != '0);
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // output stage, refilled whenever it empties or is taken
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            out_valid_out <= 1'b0;
            out_data_out <= '0;
        end else if (pop) begin
            out_valid_out <= 1'b1;
            out_data_out <= mem[rd_ptr];
        end else if (out_ready_in) begin
            out_valid_out <= 1'b0;
        end
    end
endmodule

//--- logic/srx_lane.sv
// serial receive lane: configuration, clock recovery, alignment, equalizer control
`timescale 1ns/10ps
module srx_lane #(
    parameter int LANE_INDEX = 0,
    parameter int EQ_WINDOW = srx_pkg::EQ_WINDOW_DEF,
    parameter int FIFO_DEPTH = srx_pkg::FIFO_DEPTH_DEF
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic [11:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic SERIAL_RX_PAIR_IN,
    input wire logic PHASE_SAMPLE_IN,
    input wire logic SIGNAL_LOSS_IN,
    input wire logic EQ_RAISE_IN,
    input wire logic EQ_LOWER_IN,
    output logic LANE_RECEIVER_ON_OUT,
    output logic [1:0] SIGNAL_LOSS_DETECT_SELECT_OUT,
    output logic [5:0] PHASE_CODE_OUT,
    output logic [3:0] EQ_GAIN_OUT,
    output logic [2:0] EQ_ZERO_OUT,
    output logic [9:0] SYMBOL_DATA_OUT,
    output logic SYMBOL_VALID_OUT,
    input wire logic SYMBOL_READY_IN
);
    localparam logic [11:0] CFG_ADDR = srx_pkg::CFG_BASE + 12'(LANE_INDEX) * srx_pkg::CFG_STRIDE;
    localparam int EQW = $clog2(EQ_WINDOW);

    srx_pkg::srx_cfg_t cfg;
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic bus_req, accept, hit_cfg, hit_stat;
    logic [31:0] wr_word, stat_word, next_rdata;
    logic rx_bit, ph_bit, los_active, take, cdr_take;
    logic [1:0] rate_cnt;
    logic prev_bit, vote_e, vote_l, win_end, maj_e, maj_l, second, drift_e, drift_l;
    logic [2:0] win_cnt;
    logic [3:0] early_cnt, late_cnt, e_tot, l_tot;
    logic signed [7:0] freq, freq_inc;
    logic signed [12:0] drift, next_drift, thr;
    logic [5:0] phase_code;
    logic [9:0] shreg, sh_next;
    logic [3:0] bit_cnt;
    logic comma, realign, jog_now, sym_done, prev_align_hi, jog_pending;
    logic fifo_in_ready, push_lost, ovf;
    logic [EQW-1:0] eq_cnt;
    logic [EQW:0] up_cnt, dn_cnt, up_tot, dn_tot;
    logic eq_end, raise, lower;
    logic [3:0] gain;
    logic [2:0] zero;

    // ==========================================================
    // register bus
    always_comb begin
        bus_req = AVS_READ_IN || AVS_WRITE_IN;
        accept = bus_req && !AVS_WAITREQUEST_OUT;
        hit_cfg = (AVS_ADDRESS_IN == CFG_ADDR);
        hit_stat = (AVS_ADDRESS_IN == srx_pkg::STAT_ADDR);
        wr_word = cfg;
        for (int i = 0; i < 4; i++) begin
            if (AVS_BYTEENABLE_IN[i]) begin
                wr_word[8*i +: 8] = AVS_WRITEDATA_IN[8*i +: 8];
            end
        end
        stat_word = '0;
        stat_word[srx_pkg::STAT_PHASE_LSB +: 6] = phase_code;
        stat_word[srx_pkg::STAT_FREQ_LSB +: 8] = freq;
        stat_word[srx_pkg::STAT_GAIN_LSB +: 4] = gain;
        stat_word[srx_pkg::STAT_ZERO_LSB +: 3] = zero;
        stat_word[srx_pkg::STAT_LOS_BIT] = los_active;
        stat_word[srx_pkg::STAT_OVF_BIT] = ovf;
        next_rdata = hit_cfg ? cfg : (hit_stat ? stat_word : '0);
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            AVS_WAITREQUEST_OUT <= 1'b1;
            AVS_READDATA_OUT <= '0;
        end else if (bus_req && AVS_WAITREQUEST_OUT) begin
            AVS_WAITREQUEST_OUT <= 1'b0;
            AVS_READDATA_OUT <= AVS_READ_IN ? next_rdata : '0;
        end else begin
            AVS_WAITREQUEST_OUT <= 1'b1;
        end
    end

    // read-only bits are masked at write, so they always read zero
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            cfg <= srx_pkg::CFG_RESET;
        end else if (accept && AVS_WRITE_IN && hit_cfg) begin
            cfg <= wr_word & srx_pkg::CFG_WR_MASK; // RL17 RL18
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            ovf <= 1'b0;
        end else if (push_lost) begin
            ovf <= 1'b1;
        end else if (accept && AVS_WRITE_IN && hit_stat && AVS_BYTEENABLE_IN[3]
                     && AVS_WRITEDATA_IN[srx_pkg::STAT_OVF_BIT]) begin
            ovf <= 1'b0;
        end
    end

    // ==========================================================
    // input synchronisers and sample pacing
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {EQ_LOWER_IN, EQ_RAISE_IN, SIGNAL_LOSS_IN, PHASE_SAMPLE_IN, SERIAL_RX_PAIR_IN};
            sync_b <= sync_a;
        end
    end

    always_comb begin
        rx_bit = sync_b[0] ^ cfg.polarity; // RL14
        ph_bit = sync_b[1] ^ cfg.polarity; // RL14
        los_active = sync_b[2] && (cfg.loss_sel == srx_pkg::LOS_HIGH
                                   || cfg.loss_sel == srx_pkg::LOS_LOW); // RL5 RL19
        take = cfg.rx_on && ((cfg.rate == srx_pkg::RATE_FULL)
                             || (cfg.rate == srx_pkg::RATE_HALF && rate_cnt[0])
                             || (cfg.rate == srx_pkg::RATE_QUARTER && rate_cnt == 2'h3)); // RL1 RL3
        cdr_take = take && !los_active; // RL4
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN || !cfg.rx_on) begin
            rate_cnt <= '0; // RL3
        end else begin
            rate_cnt <= rate_cnt + 2'h1;
        end
    end

    // ==========================================================
    // clock recovery
    always_comb begin
        vote_e = cdr_take && (rx_bit != prev_bit) && (ph_bit == rx_bit); // RL6
        vote_l = cdr_take && (rx_bit != prev_bit) && (ph_bit != rx_bit); // RL6
        e_tot = early_cnt + 4'(vote_e);
        l_tot = late_cnt + 4'(vote_l);
        win_end = cdr_take && (win_cnt == srx_pkg::VOTE_LAST);
        maj_e = win_end && (e_tot > l_tot); // RL6
        maj_l = win_end && (l_tot > e_tot); // RL6
        second = (cfg.recovery[1:0] != 2'h0); // RL8
        freq_inc = cfg.recovery[2] ? 8'sh02 : 8'sh01; // RL8
        case (cfg.recovery[1:0])
            2'h1: thr = srx_pkg::DRIFT_THR1;
            2'h2: thr = srx_pkg::DRIFT_THR2;
            default: thr = srx_pkg::DRIFT_THR3;
        endcase
        next_drift = drift + 13'(freq);
        drift_l = second && cdr_take && (next_drift >= thr); // RL7
        drift_e = second && cdr_take && (next_drift <= -thr); // RL7
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN || !cfg.rx_on) begin
            prev_bit <= 1'b0;
            win_cnt <= '0;
            early_cnt <= '0;
            late_cnt <= '0;
        end else if (cdr_take) begin // RL4
            prev_bit <= rx_bit;
            win_cnt <= win_cnt + 3'h1;
            early_cnt <= win_end ? 4'h0 : e_tot;
            late_cnt <= win_end ? 4'h0 : l_tot;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN || !cfg.rx_on || !second) begin
            freq <= '0; // RL7
            drift <= '0;
        end else if (cdr_take) begin // RL4
            if (maj_l && freq <= srx_pkg::FREQ_LIM - freq_inc) begin
                freq <= freq + freq_inc; // RL7
            end else if (maj_e && freq >= freq_inc - srx_pkg::FREQ_LIM) begin
                freq <= freq - freq_inc; // RL7
            end
            if (drift_l) begin
                drift <= next_drift - thr;
            end else if (drift_e) begin
                drift <= next_drift + thr;
            end else begin
                drift <= next_drift;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN || !cfg.rx_on) begin
            phase_code <= '0;
        end else begin
            phase_code <= phase_code + 6'(maj_l) + 6'(drift_l) - 6'(maj_e) - 6'(drift_e); // RL7
        end
    end

    // ==========================================================
    // symbol alignment
    always_comb begin
        sh_next = {shreg[8:0], rx_bit};
        comma = (sh_next[9:3] == srx_pkg::COMMA_POS) || (sh_next[9:3] == srx_pkg::COMMA_NEG);
        realign = (cfg.align == srx_pkg::ALIGN_COMMA) && comma
                  && (bit_cnt != srx_pkg::SYM_LAST); // RL10 RL9
        jog_now = take && jog_pending && (cfg.align == srx_pkg::ALIGN_JOG); // RL11
        sym_done = take && !jog_now && ((bit_cnt == srx_pkg::SYM_LAST) || realign);
        push_lost = sym_done && !fifo_in_ready;
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            prev_align_hi <= 1'b0;
            jog_pending <= 1'b0;
        end else begin
            prev_align_hi <= cfg.align[1];
            if (cfg.align[1] && !prev_align_hi) begin
                jog_pending <= 1'b1; // RL11
            end else if (jog_now || !cfg.align[1]) begin
                jog_pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN || !cfg.rx_on) begin
            shreg <= '0;
            bit_cnt <= '0;
        end else if (take) begin
            shreg <= sh_next;
            if (jog_now) begin
                bit_cnt <= bit_cnt; // RL11
            end else if (sym_done) begin
                bit_cnt <= '0;
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end

    srx_fifo #(
        .WIDTH(srx_pkg::SYM_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(RST_N_IN),
        .in_valid_in(sym_done),
        .in_ready_out(fifo_in_ready),
        .in_data_in(sh_next),
        .out_valid_out(SYMBOL_VALID_OUT),
        .out_ready_in(SYMBOL_READY_IN),
        .out_data_out(SYMBOL_DATA_OUT)
    );

    // ==========================================================
    // equalizer control
    always_comb begin
        up_tot = up_cnt + (EQW+1)'(sync_b[3] && !sync_b[4]);
        dn_tot = dn_cnt + (EQW+1)'(sync_b[4] && !sync_b[3]);
        eq_end = take && (eq_cnt == EQW'(EQ_WINDOW-1));
        raise = eq_end && (up_tot > dn_tot); // RL13
        lower = eq_end && (dn_tot > up_tot); // RL13
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN || !cfg.rx_on) begin
            eq_cnt <= '0;
            up_cnt <= '0;
            dn_cnt <= '0;
        end else if (take) begin
            eq_cnt <= eq_end ? '0 : eq_cnt + 1'b1;
            up_cnt <= eq_end ? '0 : up_tot;
            dn_cnt <= eq_end ? '0 : dn_tot;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN || !cfg.rx_on) begin
            gain <= srx_pkg::GAIN_MAX;
            zero <= srx_pkg::ZERO_MIN;
        end else if (cfg.gain_shaping == srx_pkg::EQ_FLAT) begin
            gain <= srx_pkg::GAIN_MAX;
        end else if (cfg.gain_shaping == srx_pkg::EQ_FULL || cfg.gain_shaping[3]) begin
            if (cfg.gain_shaping[3]) begin
                zero <= cfg.gain_shaping[2:0];
            end
            if (raise) begin
                if (gain != srx_pkg::GAIN_MAX) begin
                    gain <= gain + 4'h1;
                end else if (!cfg.gain_shaping[3] && zero != srx_pkg::ZERO_MAX) begin
                    zero <= zero + 3'h1; // RL12
                end
            end else if (lower) begin
                if (gain != srx_pkg::GAIN_MIN) begin
                    gain <= gain - 4'h1;
                end else if (!cfg.gain_shaping[3] && zero != srx_pkg::ZERO_MIN) begin
                    zero <= zero - 3'h1; // RL12
                end
            end
        end
    end

    always_comb begin
        LANE_RECEIVER_ON_OUT = cfg.rx_on; // RL18
        SIGNAL_LOSS_DETECT_SELECT_OUT = cfg.loss_sel;
        PHASE_CODE_OUT = phase_code;
        EQ_GAIN_OUT = gain;
        EQ_ZERO_OUT = zero;
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);

    a_quarter_pace: assert property (take && cfg.rate == srx_pkg::RATE_QUARTER // RL1
        |=> (!take || $changed(cfg)) [*3])
        else $error("quarter rate sampled too often");
    a_rx_off_idle: assert property (!cfg.rx_on |=> (win_cnt == 3'h0 && bit_cnt == 4'h0 // RL3
        && !sym_done && phase_code == 6'h00))
        else $error("receive logic active while off");
    a_loss_freeze: assert property (los_active && cfg.rx_on && second // RL4
        |=> (!cfg.rx_on || !second || ($stable(phase_code) && $stable(freq))))
        else $error("recovery moved during signal loss");
    a_loss_ignored: assert property (cfg.loss_sel == srx_pkg::LOS_OFF |-> !los_active) // RL5
        else $error("loss honoured while detection off");
    a_tie_no_step: assert property (win_end && e_tot == l_tot && !second // RL6
        |=> $stable(phase_code) || !cfg.rx_on)
        else $error("phase stepped without majority");
    a_first_order: assert property (cfg.rx_on && !second && (maj_e || maj_l) // RL7
        |=> 6'(phase_code - $past(phase_code)) == ($past(maj_l) ? 6'h01 : 6'h3F)
        || !cfg.rx_on)
        else $error("first order step not exactly one");
    a_align_off: assert property (cfg.align == srx_pkg::ALIGN_OFF && sym_done // RL9
        |-> bit_cnt == srx_pkg::SYM_LAST)
        else $error("realigned while alignment off");
    a_comma_align: assert property (take && cfg.align == srx_pkg::ALIGN_COMMA && comma // RL10
        |-> sym_done ##1 (bit_cnt == 4'h0 || !cfg.rx_on))
        else $error("comma did not set boundary");
    a_jog_slip: assert property (jog_now |=> bit_cnt == $past(bit_cnt) || !cfg.rx_on) // RL11
        else $error("jog did not slip one bit");
    a_zero_lower: assert property (cfg.rx_on && lower // RL12
        && cfg.gain_shaping == srx_pkg::EQ_FULL && gain == srx_pkg::GAIN_MIN
        && zero != srx_pkg::ZERO_MIN |=> zero == $past(zero) - 3'h1 || !cfg.rx_on)
        else $error("zero not lowered at min gain");
    a_eq_hold: assert property (!eq_end && cfg.gain_shaping == srx_pkg::EQ_FULL // RL13
        |=> $stable(gain) || !cfg.rx_on)
        else $error("gain moved outside decision point");
    a_polarity: assert property (take // RL14
        |=> shreg[0] == ($past(sync_b[0]) ^ $past(cfg.polarity)) || !cfg.rx_on)
        else $error("polarity not applied");
    a_ro_zero: assert property (!AVS_WAITREQUEST_OUT && AVS_READ_IN && hit_cfg // RL17
        |-> (AVS_READDATA_OUT & ~srx_pkg::CFG_WR_MASK) == 32'h00000000)
        else $error("read-only bits not zero");
    a_enable_write: assert property (accept && AVS_WRITE_IN && hit_cfg // RL18
        && AVS_BYTEENABLE_IN[0] |=> LANE_RECEIVER_ON_OUT == $past(AVS_WRITEDATA_IN[0]))
        else $error("enable bit not taken");

    c_comma: cover property (take && realign);
    c_jog: cover property (jog_now);
    c_second_step: cover property (drift_l || drift_e);
    c_overflow: cover property (push_lost);
endmodule

//--- bench/srx_tx_model.sv
// remote serial transmitter model repeating one ten-bit pattern
`timescale 1ns/10ps
module srx_tx_model (
    input wire logic clk_in,
    input wire logic [9:0] pattern_in,
    output logic data_out,
    output logic phase_out
);
    logic [3:0] pos;
    initial pos = 4'h0;
    initial data_out = 1'b0;
    initial phase_out = 1'b0;
    // one bit per clock, bit 9 first; phase lags data so edges vote late
    always @(posedge clk_in) begin
        data_out <= pattern_in[4'h9 - pos];
        phase_out <= data_out;
        pos <= (pos == 4'h9) ? 4'h0 : pos + 4'h1;
    end
endmodule

//--- bench/srx_lane_tb_top.sv
// self-checking testbench for the serial receive lane
`timescale 1ns/10ps
module srx_lane_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, signal_loss_detect_select = 1'b0, rdy = 1'b1;
    logic eqr = 1'b0, eql = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wd = 32'h00000000, rdat, q;
    logic wreq, ser, ph, rxon, sv;
    logic [1:0] lsel;
    logic [5:0] phc, p0;
    logic [3:0] gain;
    logic [2:0] zero;
    logic [9:0] sd, last = 10'h000, pat = 10'h000;
    int n_fail = 0, compares = 0, nsym = 0, n0;

    srx_tx_model tx (.clk_in(clk), .pattern_in(pat), .data_out(ser), .phase_out(ph));
    srx_lane #(.EQ_WINDOW(16)) uut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(adr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hF),
        .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq), .SERIAL_RX_PAIR_IN(ser),
        .PHASE_SAMPLE_IN(ph), .SIGNAL_LOSS_IN(signal_loss_detect_select), .EQ_RAISE_IN(eqr), .EQ_LOWER_IN(eql),
        .LANE_RECEIVER_ON_OUT(rxon), .SIGNAL_LOSS_DETECT_SELECT_OUT(lsel),
        .PHASE_CODE_OUT(phc), .EQ_GAIN_OUT(gain), .EQ_ZERO_OUT(zero),
        .SYMBOL_DATA_OUT(sd), .SYMBOL_VALID_OUT(sv), .SYMBOL_READY_IN(rdy));

    initial forever #12.5 clk = ~clk;

    always @(posedge clk) begin
        if (sv === 1'b1 && rdy === 1'b1) begin
            nsym <= nsym + 1;
            last <= sd;
        end
    end

    // ==========================================================
    // shared tasks
    task conclude;
        if (n_fail == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= ~w;
        wd <= d;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    function automatic logic [31:0] cfg(logic [1:0] r, logic p, logic [1:0] al, logic [1:0] ls);
        cfg = 32'h00000101 | {24'h0, p, r, 5'h00} | {16'h0000, ls, al, 12'h000};
    endfunction

    // ==========================================================
    // scenarios
    task t_regs;
        chk(gain, 4'hF);
        bus(1'b0, 12'h100, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 12'h100, 32'hFCFFF9E1);
        bus(1'b0, 12'h100, 32'h0);
        chk(q, 32'h007FF1E1);
        chk({rxon, lsel}, 3'h7);
        bus(1'b0, 12'h104, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 12'h100, 32'h00000100);
        cyc(1);
        chk(rxon, 1'b0);
    endtask
    task t_rate;
        for (int r = 0; r < 4; r++) begin
            bus(1'b1, 12'h100, cfg(r[1:0], 1'b1, 2'h0, 2'h0));
            cyc(50);
            n0 = nsym;
            cyc(400);
            n0 = nsym - n0 - ((r == 3) ? 0 : 400 / (10 << r));
            chk(n0 >= -1 && n0 <= 1, 1'b1);
            if (r < 3) chk(last, 10'h3FF);
        end
        bus(1'b1, 12'h100, cfg(2'h0, 1'b0, 2'h0, 2'h0));
        cyc(60);
        chk(last, 10'h000);
        bus(1'b1, 12'h100, 32'h00000100);
        cyc(30);
        n0 = nsym;
        cyc(200);
        chk(nsym - n0, 0);
    endtask
    task t_fifo;
        rdy <= 1'b0;
        bus(1'b1, 12'h100, cfg(2'h0, 1'b0, 2'h0, 2'h0));
        cyc(300);
        bus(1'b1, 12'h100, 32'h00000100);
        bus(1'b0, 12'h180, 32'h0);
        chk(q[25], 1'b1);
        bus(1'b1, 12'h180, 32'h02000000);
        bus(1'b0, 12'h180, 32'h0);
        chk(q[25], 1'b0);
        n0 = nsym;
        rdy <= 1'b1;
        cyc(60);
        chk(nsym - n0, 17);
    endtask
    task t_comma;
        pat <= 10'h0FA;
        bus(1'b1, 12'h100, cfg(2'h0, 1'b0, 2'h1, 2'h0));
        cyc(200);
        chk(last, 10'h0FA);
        bus(1'b1, 12'h100, cfg(2'h0, 1'b0, 2'h0, 2'h0));
        cyc(100);
        chk(last, 10'h0FA);
    endtask
    task t_los;
        pat <= 10'h2AA;
        bus(1'b1, 12'h100, cfg(2'h0, 1'b0, 2'h0, 2'h1));
        cyc(20);
        p0 = phc;
        cyc(96);
        chk(6'(phc - p0), 6'h0C);
        bus(1'b1, 12'h100, cfg(2'h0, 1'b0, 2'h0, 2'h1) | 32'h00030000);
        cyc(40);
        signal_loss_detect_select <= 1'b1;
        cyc(10);
        p0 = phc;
        cyc(96);
        chk(phc, p0);
        bus(1'b0, 12'h180, 32'h0);
        chk(q[15:8] >= 8'h04 && q[15:8] <= 8'h06, 1'b1);
        bus(1'b1, 12'h100, cfg(2'h0, 1'b0, 2'h0, 2'h0));
        cyc(10);
        p0 = phc;
        cyc(96);
        chk(6'(phc - p0), 6'h0C);
    endtask
    task t_jog;
        bus(1'b1, 12'h100, cfg(2'h0, 1'b0, 2'h2, 2'h0));
        cyc(60);
        chk(last, 10'h1F4);
        bus(1'b1, 12'h100, cfg(2'h0, 1'b0, 2'h0, 2'h0));
        bus(1'b1, 12'h100, cfg(2'h0, 1'b0, 2'h2, 2'h0));
        cyc(60);
        chk(last, 10'h3E8);
    endtask
    task t_eq;
        eql <= 1'b1;
        bus(1'b1, 12'h100, 32'h00080101);
        cyc(300);
        chk(gain, 4'h0);
        {eqr, eql} <= 2'h2;
        cyc(330);
        chk({gain, (zero != 3'h0)}, 5'h1F);
        {eqr, eql} <= 2'h1;
        cyc(400);
        chk({gain, zero}, 7'h00);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        cyc(4);
        rst_n <= 1'b1;
        t_regs();
        t_rate();
        t_fifo();
        t_comma();
        t_jog();
        t_los();
        t_eq();
        conclude();
    end
    initial begin
        cyc(20000);
        n_fail++;
        conclude();
    end
endmodule
